// ==== rtl/asf_defs.svh ====
/*
 Constants for the converter status register block: offsets, field positions,
 reset values and clamp codes. Assumes it is included by bare name.
*/
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses as carried in the command byte.
// ----------------------------------------------------------------------------
`define ASF_ADDR_STATUS 6'h00
`define ASF_ADDR_DATA 6'h04

// ----------------------------------------------------------------------------
// Status register layout and reset value.
// ----------------------------------------------------------------------------
`define ASF_STATUS_RESET 8'h80
`define ASF_BIT_READY_N 7
`define ASF_BIT_RANGE 6
`define ASF_BIT_CHECKSUM 5
`define ASF_BIT_INTEGRITY 4

// ----------------------------------------------------------------------------
// Result clamp codes and widths.
// ----------------------------------------------------------------------------
`define ASF_CLAMP_HIGH 24'hFFFFFF
`define ASF_CLAMP_LOW 24'h000000
`define ASF_SIG_WIDTH 32

`endif

// ==== rtl/asf_pkg.sv ====
/*
 Types shared by the status register block and its helpers.
 Assumes asf_defs.svh sits on the include path.
*/
`default_nettype none
package asf_pkg;

   // -------------------------------------------------------------------------
   // Status register image.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic ready_n;       // Low when an unread result is held.
      logic range_err;     // Last result was clamped.
      logic checksum_err;  // A register write failed its checksum.
      logic integrity_err; // Register contents drifted from the signature.
      logic [1:0] rsvd;    // Always zero.
      logic [1:0] channel; // Channel of the held result.
   } asf_status_t;

   // -------------------------------------------------------------------------
   // One conversion or calibration result as offered by the engine.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic valid;        // One-cycle write strobe.
      logic calib;        // The write is a calibration result.
      logic over;         // Input was above range.
      logic under;        // Input was below range.
      logic [1:0] channel; // Channel converted.
      logic [23:0] value;  // Raw result.
   } asf_result_t;

endpackage : asf_pkg
`default_nettype wire

// ==== rtl/asf_sync.sv ====
/*
 Two-flop synchroniser for one level arriving from a pin.
 Assumes the pin is asynchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none

module asf_sync
(
   input wire logic i_clock, // System clock.
   input wire logic i_rst,   // Synchronous reset, active high.
   input wire logic i_ce,    // Clock enable.
   input wire logic i_level, // Asynchronous level.
   output logic o_level      // Synchronised level.
);
   import asf_pkg::*;

   // -------------------------------------------------------------------------
   // State.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic meta; // First stage, read only by the second.
      logic sync; // Second stage.
   } asf_sync_st_t;

   asf_sync_st_t st_r; // Registered state.
   asf_sync_st_t st_nxt; // Next state.

   // Shift the level along the chain.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.meta = i_level;
      st_nxt.sync = st_r.meta;
   end

   // Register the chain; resets to the idle-high pin level.
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         st_r <= 2'b11;
      end
      else if (i_ce)
      begin
         st_r <= st_nxt;
      end
   end

   assign o_level = st_r.sync;

endmodule : asf_sync
`default_nettype wire

// ==== rtl/asf_sig.sv ====
/*
 Folds the watched configuration registers into a 32-bit signature.
 Purely combinational; assumes the watched bus is stable between writes.
*/
`timescale 1ns/1ps
`default_nettype none

module asf_sig
(
   input wire logic [127:0] i_regs, // Watched register contents.
   output logic [31:0] o_sig        // Signature.
);
   import asf_pkg::*;

   // Rotate-and-xor fold; cheap, and sensitive to any single-bit change.
   function automatic logic [31:0] fold(input logic [127:0] d);
      logic [31:0] acc;
      acc = 32'h00000000;
      for (int k = 0; k < 4; k++)
      begin
         acc = {acc[30:0], acc[31]} ^ d[k*32 +: 32];
      end
      return acc;
   endfunction : fold

   assign o_sig = fold(i_regs);

endmodule : asf_sig
`default_nettype wire

// ==== rtl/asf_status.sv ====
/*
 Status register of the converter: ready flag, range, checksum and integrity
 errors, held channel, pin output and appended-status request.
 Assumes the serial framer decodes command bytes and strobes reads; chip
 select arrives from a pin and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asf_defs.svh"

module asf_status
(
   input wire logic i_clock,                 // 20 MHz master clock.
   input wire logic i_rst,                   // Synchronous reset, active high.
   input wire logic i_ce,                    // Clock enable; low freezes all.
   input wire logic i_cs_n,                  // Chip select pin, active low.
   input wire logic i_reg_read_busy,         // Framer is shifting a register out.
   input wire logic i_read_strobe,           // One-cycle pulse: register read done.
   input wire logic [5:0] i_target_register_address, // Address of that read.
   input wire logic i_wr_checksum_bad,       // One-cycle pulse: bad write checksum.
   input wire logic i_append_status_enable,  // Append status after data reads.
   input wire logic i_integrity_check_enable, // Integrity checking on.
   input wire logic [127:0] i_watched_regs,  // Contents under integrity watch.
   input wire asf_pkg::asf_result_t i_result, // Result write from the engine.
   output logic [7:0] o_status,              // Status register image.
   output logic [23:0] o_data,               // Held (clamped) result.
   output logic o_append_req,                // Pulse: send status byte now.
   output logic o_serial_out_ready_pin,      // Ready level for the output pin.
   output logic o_serial_out_ready_oe        // High while the pin is driven.
);
   import asf_pkg::*;

   // -------------------------------------------------------------------------
   // State.
   // -------------------------------------------------------------------------
   typedef struct packed {
      asf_status_t status;  // Register image.
      logic [23:0] data;    // Held result.
      logic [31:0] ref_sig; // Signature captured at enable.
      logic chk_en;         // Previous enable, for edge detection.
      logic append;         // Append request pulse.
      logic pin;            // Pin level.
      logic oe;             // Pin enable.
   } asf_state_t;

   asf_state_t st_r; // Registered state.
   asf_state_t st_nxt; // Next state.
   logic cs_n_sync; // Synchronised chip select.
   logic [31:0] live_sig; // Current signature.
   logic data_rd; // Data register read completes.
   logic stat_rd; // Status register read completes.

   // -------------------------------------------------------------------------
   // Helpers.
   // -------------------------------------------------------------------------
   // Chip select comes from a pin, so it is synchronised first.
   asf_sync u_cs_sync
   (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_level(i_cs_n),
      .o_level(cs_n_sync)
   );

   asf_sig u_sig
   (
      .i_regs(i_watched_regs),
      .o_sig(live_sig)
   );

   // Clamp a raw result to the rail codes when out of range.
   function automatic logic [23:0] clamp(input asf_result_t r);
      logic [23:0] v;
      v = r.value;
      if (r.over)
      begin
         v = `ASF_CLAMP_HIGH;
      end
      else if (r.under)
      begin
         v = `ASF_CLAMP_LOW;
      end
      return v;
   endfunction : clamp

   // Decode one completed read of a given register; shared by both decodes.
   function automatic logic read_hit(input logic strobe, input logic [5:0] addr,
                                     input logic [5:0] target);
      return strobe && (addr == target);
   endfunction : read_hit

   assign data_rd = read_hit(i_read_strobe, i_target_register_address, `ASF_ADDR_DATA);
   assign stat_rd = read_hit(i_read_strobe, i_target_register_address, `ASF_ADDR_STATUS);

   // -------------------------------------------------------------------------
   // Next-state logic.
   // -------------------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.append = 1'b0;
      st_nxt.chk_en = i_integrity_check_enable;

      if (data_rd)
      begin
         st_nxt.status.ready_n = 1'b1;
      end

      // Status byte follows a data read.
      if (data_rd && i_append_status_enable)
      begin
         st_nxt.append = 1'b1;
      end

      // A new result beats a same-cycle data read, so no result is lost.
      if (i_result.valid)
      begin
         st_nxt.status.ready_n = 1'b0;
         if (!i_result.calib)
         begin
            st_nxt.status.range_err = i_result.over || i_result.under;
            st_nxt.data = clamp(i_result);
            st_nxt.status.channel = i_result.channel;
         end
      end

      if (stat_rd)
      begin
         st_nxt.status.checksum_err = 1'b0;
      end
      if (i_wr_checksum_bad)
      begin
         st_nxt.status.checksum_err = 1'b1;
      end

      if (i_integrity_check_enable && !st_r.chk_en)
      begin
         st_nxt.ref_sig = live_sig;
      end
      if (i_integrity_check_enable && st_r.chk_en && (live_sig != st_r.ref_sig))
      begin
         st_nxt.status.integrity_err = 1'b1;
      end
      // Only disabling the check clears it.
      if (!i_integrity_check_enable)
      begin
         st_nxt.status.integrity_err = 1'b0;
      end

      st_nxt.status.rsvd = 2'b00;

      // Ready on pin when selected and idle.
      st_nxt.oe = !cs_n_sync && !i_reg_read_busy;
      st_nxt.pin = st_nxt.status.ready_n;
   end

   // -------------------------------------------------------------------------
   // State register.
   // -------------------------------------------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         st_r <= '0;
         st_r.status <= `ASF_STATUS_RESET;
         st_r.pin <= 1'b1;
      end
      else if (i_ce)
      begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from state.
   // -------------------------------------------------------------------------
   assign o_status = st_r.status;
   assign o_data = st_r.data;
   assign o_append_req = st_r.append;
   assign o_serial_out_ready_pin = st_r.pin;
   assign o_serial_out_ready_oe = st_r.oe;

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   reset_value_a: assert property (@(posedge i_clock) $fell(i_rst) |-> o_status == 8'h80)
      else $error("status not 0x80 after reset");
   append_pulse_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && data_rd && i_append_status_enable) |=> o_append_req)
      else $error("append request missing");
   pin_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && o_serial_out_ready_oe && $past(i_ce)) |-> o_serial_out_ready_pin == o_status[7])
      else $error("pin does not show ready");
   ready_low_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid) |=> !o_status[7])
      else $error("ready not cleared on result");
   ready_high_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && data_rd && !i_result.valid) |=> o_status[7])
      else $error("ready not set on data read");
   range_clamp_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid && !i_result.calib && i_result.over)
      |=> o_status[6] && o_data == 24'hFFFFFF)
      else $error("overrange not flagged or clamped");
   range_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && !i_result.valid) |=> $stable(o_status[6]))
      else $error("range flag moved without a result");
   checksum_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_wr_checksum_bad) |=> o_status[5])
      else $error("checksum flag not set");
   checksum_clr_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && stat_rd && !i_wr_checksum_bad) |=> !o_status[5])
      else $error("checksum flag not cleared by read");
   integ_clr_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && $past(i_ce) && o_status[4] && $past(o_status[4]) == 1'b0)
      |-> $past(i_integrity_check_enable))
      else $error("integrity error set while disabled");
   reserved_zero_a: assert property (@(posedge i_clock) disable iff (i_rst)
      o_status[3:2] == 2'b00)
      else $error("reserved bits not zero");
   channel_track_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && !i_result.valid) |=> $stable(o_status[1:0]))
      else $error("channel changed without a result");

   // -------------------------------------------------------------------------
   // Further checks on loads, clears and the pin enable.
   // -------------------------------------------------------------------------
   // A calibration write touches only the ready flag.
   calib_ready_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid && i_result.calib)
      |=> !o_status[7] && $stable(o_data) && $stable(o_status[6]))
      else $error("calibration write mishandled");
   // Underrange clamps to the low rail.
   under_clamp_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid && !i_result.calib && i_result.under && !i_result.over)
      |=> o_status[6] && o_data == 24'h000000)
      else $error("underrange not flagged or clamped");
   // An in-range result clears the range flag.
   range_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid && !i_result.calib && !i_result.over && !i_result.under)
      |=> !o_status[6])
      else $error("range flag not cleared by a good result");
   // Enabling the check captures the live signature.
   ref_capture_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_integrity_check_enable && !st_r.chk_en) |=> st_r.ref_sig == $past(live_sig))
      else $error("signature not captured at enable");
   // Drift from the captured signature raises the error.
   integ_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_integrity_check_enable && st_r.chk_en && live_sig != st_r.ref_sig)
      |=> o_status[4])
      else $error("integrity drift not flagged");
   // The error stays while checking stays enabled.
   integ_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_integrity_check_enable && o_status[4]) |=> o_status[4])
      else $error("integrity error cleared while enabled");
   // Disabling the check clears the error.
   integ_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && !i_integrity_check_enable) |=> !o_status[4])
      else $error("integrity error kept after disable");
   // A conversion result write loads its channel number.
   channel_load_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && i_result.valid && !i_result.calib) |=> o_status[1:0] == $past(i_result.channel))
      else $error("channel not loaded from result");
   // Selection with no read in progress enables the pin.
   oe_on_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && !cs_n_sync && !i_reg_read_busy) |=> o_serial_out_ready_oe)
      else $error("pin not driven while selected and idle");
   // Deselection or a register read releases the pin.
   oe_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && (cs_n_sync || i_reg_read_busy)) |=> !o_serial_out_ready_oe)
      else $error("pin driven while deselected or reading");
   // The append request is a single pulse after a data read.
   append_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_ce && !data_rd) |=> !o_append_req)
      else $error("append request without a data read");

endmodule : asf_status
`default_nettype wire

// ==== dv/asf_host_model.sv ====
/*
 Host microcontroller as seen through the serial framer: chip select,
 register reads and failed write checksums.
 Assumes one shared clock; drives 5 ns after each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module asf_host_model
(
   input wire logic i_clock,  // Shared clock.
   output logic o_cs_n,       // Chip select, active low.
   output logic o_busy,       // Register shift in progress.
   output logic o_strobe,     // Read completed pulse.
   output logic [5:0] o_addr, // Address of the read.
   output logic o_bad_wr      // Write checksum failure pulse.
);
   // --------------------------------------------------------------------
   // Idle state.
   // --------------------------------------------------------------------
   initial
   begin
      o_cs_n = 1'b1;
      o_busy = 1'b0;
      o_strobe = 1'b0;
      o_addr = 6'h3F;
      o_bad_wr = 1'b0;
   end

   // Read checksums stay the host's job, so nothing is flagged here.
   task automatic read_reg(input logic [5:0] addr);
      @(posedge i_clock);
      #5;
      o_addr = addr;
      o_strobe = 1'b1;
      @(posedge i_clock);
      #5;
      o_strobe = 1'b0;
      // A released address shows the inverse, never a stale match.
      o_addr = ~addr;
   endtask : read_reg

   // One write whose checksum failed.
   task automatic bad_write();
      @(posedge i_clock);
      #5;
      o_bad_wr = 1'b1;
      @(posedge i_clock);
      #5;
      o_bad_wr = 1'b0;
   endtask : bad_write

   // Chip select and shift activity for a frame.
   task automatic frame(input logic cs_n, input logic busy);
      @(posedge i_clock);
      #5;
      o_cs_n = cs_n;
      o_busy = busy;
   endtask : frame
endmodule : asf_host_model
`default_nettype wire

// ==== dv/adc_status_flags_tb.sv ====
/*
 Self-checking bench for the status register block.
 Assumes the host model drives the framer side; i_ce drops once to show the freeze.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_status_flags_tb;
   import asf_pkg::*;
   logic clk = 1'b0, rst = 1'b1, app_en = 1'b0, int_en = 1'b0, ce = 1'b1;
   logic cs_n, busy, strb, bad, app, pin, oe;
   logic [5:0] addr;
   logic [127:0] watched = '0;
   asf_result_t res = '0;
   logic [7:0] status;
   logic [23:0] data;
   int err_total = 0, checks_done = 0;

   always #25 clk = ~clk;

   asf_host_model i_host (.i_clock(clk), .o_cs_n(cs_n), .o_busy(busy),
      .o_strobe(strb), .o_addr(addr), .o_bad_wr(bad));

   asf_status i_dut (.i_clock(clk), .i_rst(rst), .i_ce(ce), .i_cs_n(cs_n),
      .i_reg_read_busy(busy), .i_read_strobe(strb),
      .i_target_register_address(addr), .i_wr_checksum_bad(bad),
      .i_append_status_enable(app_en), .i_integrity_check_enable(int_en),
      .i_watched_regs(watched), .i_result(res), .o_status(status),
      .o_data(data), .o_append_req(app), .o_serial_out_ready_pin(pin),
      .o_serial_out_ready_oe(oe));

   // --------------------------------------------------------------------
   // Shared helpers.
   // --------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : step

   // One engine write; outputs are settled when this returns.
   task automatic put(input logic cal, input logic ov, input logic un,
                      input logic [1:0] ch, input logic [23:0] v);
      res = '{1'b1, cal, ov, un, ch, v};
      step(1);
      res.valid = 1'b0;
   endtask : put

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   // --------------------------------------------------------------------
   // Scenarios.
   // --------------------------------------------------------------------
   task automatic t_over_append();
      put(1'b0, 1'b1, 1'b0, 2'h2, 24'h0055AA);
      chk(status, 8'h42);
      chk(data, 24'hFFFFFF);
      app_en = 1'b1;
      i_host.read_reg(6'h04);
      chk(app, 1'b1);
      chk(status, 8'hC2);
      step(1);
      chk(app, 1'b0);
   endtask : t_over_append

   task automatic t_range_cal();
      put(1'b0, 1'b0, 1'b1, 2'h3, 24'h123456);
      chk({status, data}, {8'h43, 24'h000000});
      put(1'b0, 1'b0, 1'b0, 2'h1, 24'h123456);
      chk({status, data}, {8'h01, 24'h123456});
      i_host.read_reg(6'h04);
      chk(status, 8'h81);
      // Calibration write touches the ready flag only.
      put(1'b1, 1'b1, 1'b0, 2'h0, 24'h000000);
      chk({status, data}, {8'h01, 24'h123456});
      // A result landing with a data read must stay flagged as unread.
      fork
         i_host.read_reg(6'h04);
         begin
            step(1);
            put(1'b0, 1'b0, 1'b0, 2'h2, 24'h00ABCD);
         end
      join
      chk({status, data}, {8'h02, 24'h00ABCD});
   endtask : t_range_cal

   task automatic t_checksum();
      i_host.bad_write();
      chk(status, 8'h22);
      i_host.read_reg(6'h00);
      chk(status, 8'h02);
      chk(app, 1'b0);
      // A failed write in the cycle of a status read keeps the flag set.
      fork
         i_host.bad_write();
         i_host.read_reg(6'h00);
      join
      chk(status, 8'h22);
      i_host.read_reg(6'h00);
      chk(status, 8'h02);
   endtask : t_checksum

   task automatic t_integrity();
      // A non-zero image at enable must not count as drift.
      watched = 128'h5A;
      int_en = 1'b1;
      step(3);
      chk(status[4], 1'b0);
      watched = 128'h1;
      step(3);
      chk(status[4], 1'b1);
      // Restoring the contents must not clear the sticky error.
      watched = 128'h5A;
      step(3);
      chk(status[4], 1'b1);
      int_en = 1'b0;
      step(2);
      chk(status[4], 1'b0);
      // A second enable takes a fresh signature of the new contents.
      watched = 128'h1;
      int_en = 1'b1;
      step(3);
      chk(status[4], 1'b0);
   endtask : t_integrity

   task automatic t_pin();
      i_host.frame(1'b0, 1'b0);
      step(4);
      chk({oe, pin}, 2'b10);
      // The pin follows the ready flag while selected.
      i_host.read_reg(6'h04);
      chk({oe, pin}, 2'b11);
      put(1'b0, 1'b0, 1'b0, 2'h1, 24'h000777);
      chk({oe, pin}, 2'b10);
      i_host.frame(1'b0, 1'b1);
      step(4);
      chk(oe, 1'b0);
      i_host.frame(1'b1, 1'b0);
      step(4);
      chk(oe, 1'b0);
   endtask : t_pin

   // With the clock enable low, neither a result nor a bad write may land.
   task automatic t_freeze();
      ce = 1'b0;
      put(1'b0, 1'b1, 1'b0, 2'h3, 24'h000001);
      i_host.bad_write();
      chk({status, data}, {8'h01, 24'h000777});
      ce = 1'b1;
   endtask : t_freeze

   // A reset in mid-run brings back the reset image.
   task automatic t_reset();
      i_host.bad_write();
      rst = 1'b1;
      step(3);
      rst = 1'b0;
      chk({status, data}, {8'h80, 24'h000000});
      chk({app, oe, pin}, 3'b001);
      put(1'b0, 1'b0, 1'b0, 2'h1, 24'h000010);
      chk({status, data}, {8'h01, 24'h000010});
   endtask : t_reset

   // --------------------------------------------------------------------
   // Main sequence and watchdog.
   // --------------------------------------------------------------------
   initial
   begin
      step(3);
      chk(status, 8'h80);
      chk(data, 24'h000000);
      chk({app, oe, pin}, 3'b001);
      rst = 1'b0;
      t_over_append();
      t_range_cal();
      t_checksum();
      t_integrity();
      t_pin();
      t_freeze();
      t_reset();
      finish_test();
   end

   // The tests need about 65 cycles; 2000 means a hang.
   initial
   begin
      #(2000 * 50);
      err_total++;
      finish_test();
   end
endmodule : adc_status_flags_tb
`default_nettype wire
